// [design/tcp_pkg.sv]
/*
 * Shared constants for the two-channel compare/PWM timer: register
 * offsets, field positions, reset values and action encodings.
 * Assumes a 32-bit APB register bus with byte addressing.
 */
package tcp_pkg;
   localparam int CNT_W = 16;
   localparam int PRE_W = 6;
   localparam int AW = 8;

   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_COUNT = 8'h04;
   localparam logic [7:0] A_PERIOD = 8'h08;
   localparam logic [7:0] A_C0CTL = 8'h0c;
   localparam logic [7:0] A_C0VAL = 8'h10;
   localparam logic [7:0] A_C1CTL = 8'h14;
   localparam logic [7:0] A_C1VAL = 8'h18;

   // timer_ctrl_stat fields
   localparam int B_WFLAG = 7;
   localparam int B_WIE = 6;
   localparam int B_HALT = 5;
   localparam int B_CLR = 4;
   localparam int B_PS = 0;
   localparam int PS_W = 3;

   // chanN_ctrl_stat fields
   localparam int B_FLAG = 7;
   localparam int B_IEN = 6;
   localparam int B_MHI = 5;
   localparam int B_MLO = 4;
   localparam int B_AHI = 3;
   localparam int B_ALO = 2;
   localparam int B_TOG = 1;
   localparam int B_FULL = 0;

   localparam logic [2:0] PS_EXT = 3'h7;
   localparam logic HALT_RST = 1'b1;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] MATCH_RST = 16'h0000;
   localparam logic [7:0] CCTL_RST = 8'h00;
   localparam logic [6:0] CCTL_WMASK = 7'h7f;
   localparam logic [7:0] C1_RMASK = 8'hdf;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // Compare action encodings (chan_action_hi:chan_action_lo)
   localparam logic [1:0] ACT_TOG = 2'h1;
   localparam logic [1:0] ACT_CLR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// [design/tcp_counter.sv]
/*
 * Prescaler and 16-bit modulo up-counter of the timer.
 * Assumes halt, clear and freeze are synchronous to mclk.
 */
`timescale 1ns/1ps
module tcp_counter #(
   parameter int W = tcp_pkg::CNT_W
) (
   input wire logic mclk, // System clock
   input wire logic reset, // Async reset, active high
   input wire logic halt, // counter_halt
   input wire logic clear, // One-cycle counter and prescaler clear
   input wire logic freeze, // Stop mode freeze
   input wire logic [2:0] ps, // Prescaler select
   input wire logic [W-1:0] period, // period_limit
   output logic [W-1:0] count, // Counter value
   output logic adv, // Pulse: count just changed
   output logic wrap // Pulse: count just wrapped to zero
);
   typedef struct packed {
      logic [W-1:0] count;
      logic [tcp_pkg::PRE_W-1:0] presc;
      logic adv;
      logic wrap;
   } tcp_cnt_t;

   tcp_cnt_t c_reg;
   tcp_cnt_t c_next;
   logic [tcp_pkg::PRE_W-1:0] mask;

   if (W < 2 || W > 32) begin : g_chk
      $error("tcp_counter: W out of range");
   end

   always_comb begin
      c_next = c_reg;
      c_next.adv = 1'b0;
      c_next.wrap = 1'b0;
      mask = tcp_pkg::PRE_W'((1 << ps) - 1);
      if (clear) begin
         c_next.count = '0; // see RL25
         c_next.presc = '0;
      end else if (~halt & ~freeze & (ps != tcp_pkg::PS_EXT)) begin // see RL24
         // see RL23
         if ((c_reg.presc & mask) == mask) begin
            c_next.presc = '0;
            c_next.adv = 1'b1;
            if (c_reg.count == period) begin // see RL11
               c_next.count = '0;
               c_next.wrap = 1'b1; // see RL2
            end else begin
               c_next.count = c_reg.count + W'(1);
            end
         end else begin
            c_next.presc = c_reg.presc + tcp_pkg::PRE_W'(1);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         c_reg <= '0;
      end else begin
         c_reg <= c_next;
      end
   end

   assign count = c_reg.count;
   assign adv = c_reg.adv;
   assign wrap = c_reg.wrap;
endmodule

// [design/tcp_top.sv]
/*
 * Two-channel output-compare and PWM timer with APB registers.
 * Assumes an APB master on mclk and port logic that owns chan1_pin
 * whenever its output enable is low.
 */
// The placing of the registers and register access over APB were decided locally.
// Operation
// RL1: Channel event at compare ending the pulse
// RL2: Overflow event when counter wraps
// RL3: Software times unbuffered writes by interrupts
// RL4: pair_buffer_sel pairs channels, output on chan0_pin
// RL5: Written pair takes over at next overflow
// RL6: Channel 0 control governs pair; channel 1 ignored
// RL7: Channel 1 pin released while paired
// RL8: Software writes only the inactive pair
// RL9: Toggle on wrap sets PWM period
// RL10: Compare drives pin inactive, ending pulse
// RL11: Counter runs zero through period inclusive
// RL12: Eight-bit period gives 256 width steps
// RL13: Mode 0:1 single, 1:0 paired
// RL14: Action 1:0 clears, 1:1 sets
// RL15: Software halts, clears, configures, then starts
// RL16: Software avoids toggle-on-compare for PWM
// RL17: Paired mode wins over single mode
// RL18: No wrap toggle gives zero duty
// RL19: Full-duty bit without toggle holds active
// RL20: Wrap flag set; request when enabled
// RL21: Channel flag on compare; request when enabled
// RL22: Keeps running in wait; request wakes
// RL23: Stop mode freezes and resumes intact
// RL24: Halt bit stops counter; set at reset
// RL25: Clear bit zeroes counter, reads zero
// RL26: Wrap flag clears by read then zero
// RL27: Channel 1 output enable dropped when paired
`timescale 1ns/1ps
module tcp_top (
   input wire logic mclk, // System clock, 10 MHz
   input wire logic reset, // Async reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic stop_mode, // Low-power stop, freezes timer
   output logic chan0_pin_out, // chan0_pin drive level
   output logic chan0_pin_oe, // chan0_pin output enable
   output logic chan1_pin_out, // chan1_pin drive level
   output logic chan1_pin_oe, // chan1_pin output enable
   output logic irq // Interrupt and wake request
);
   typedef struct packed {
      logic wflag;
      logic wie;
      logic halt;
      logic armed;
      logic [2:0] ps;
      logic clr;
      logic [15:0] period;
      logic [1:0][7:0] cctl;
      logic [1:0][15:0] cmatch;
      logic [1:0] carmed;
      logic act_sel;
      logic last_sel;
      logic [1:0] pin;
      logic [1:0] oe;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic irq;
   } tcp_state_t;

   tcp_state_t s_reg;
   tcp_state_t s_next;
   logic [15:0] cnt_val;
   logic cnt_adv;
   logic cnt_wrap;
   logic fin;
   logic wr;
   logic rd;
   logic linked;
   logic [1:0] ch_en;
   logic [1:0] ch_hit;
   logic [1:0] ch_act;
   logic [15:0] ch_match;
   logic [31:0] rdata;
   logic rhit;

   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Counter

   tcp_counter #(
      .W(tcp_pkg::CNT_W)
   ) u_cnt (
      .mclk(mclk),
      .reset(reset),
      .halt(s_reg.halt),
      .clear(s_reg.clr),
      .freeze(stop_mode),
      .ps(s_reg.ps),
      .period(s_reg.period),
      .count(cnt_val),
      .adv(cnt_adv),
      .wrap(cnt_wrap)
   );

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_next = s_reg;
      s_next.clr = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.pready = psel & penable & ~s_reg.pready;
      fin = psel & penable & s_reg.pready;
      rhit = 1'b1;
      rdata = tcp_pkg::RD_ZERO;
      unique case (1'b1)
         is_reg(paddr, tcp_pkg::A_CTRL): begin
            rdata[tcp_pkg::B_WFLAG] = s_reg.wflag;
            rdata[tcp_pkg::B_WIE] = s_reg.wie;
            rdata[tcp_pkg::B_HALT] = s_reg.halt;
            rdata[tcp_pkg::B_PS +: tcp_pkg::PS_W] = s_reg.ps; // see RL25
         end
         is_reg(paddr, tcp_pkg::A_COUNT): rdata[15:0] = cnt_val;
         is_reg(paddr, tcp_pkg::A_PERIOD): rdata[15:0] = s_reg.period;
         is_reg(paddr, tcp_pkg::A_C0CTL): rdata[7:0] = s_reg.cctl[0];
         is_reg(paddr, tcp_pkg::A_C0VAL): rdata[15:0] = s_reg.cmatch[0];
         is_reg(paddr, tcp_pkg::A_C1CTL): begin
            rdata[7:0] = s_reg.cctl[1] & tcp_pkg::C1_RMASK;
         end
         is_reg(paddr, tcp_pkg::A_C1VAL): rdata[15:0] = s_reg.cmatch[1];
         default: rhit = 1'b0;
      endcase
      if (psel & penable & ~s_reg.pready) begin
         s_next.prdata = rdata;
         s_next.pslverr = ~rhit;
      end
      wr = fin & pwrite & rhit;
      rd = fin & ~pwrite & rhit;

      // Wrap flag: arm on a read that sees it set
      if (rd && is_reg(paddr, tcp_pkg::A_CTRL) && s_reg.wflag) begin
         s_next.armed = 1'b1;
      end
      if (cnt_wrap) begin
         s_next.wflag = 1'b1; // see RL20
         s_next.armed = 1'b0; // see RL26
      end else if (wr && is_reg(paddr, tcp_pkg::A_CTRL) && s_reg.armed &&
                   !pwdata[tcp_pkg::B_WFLAG]) begin
         s_next.wflag = 1'b0; // see RL26
         s_next.armed = 1'b0;
      end

      if (wr && is_reg(paddr, tcp_pkg::A_CTRL)) begin
         s_next.wie = pwdata[tcp_pkg::B_WIE];
         s_next.halt = pwdata[tcp_pkg::B_HALT]; // see RL24
         s_next.clr = pwdata[tcp_pkg::B_CLR]; // see RL25
         s_next.ps = pwdata[tcp_pkg::B_PS +: tcp_pkg::PS_W];
      end
      if (wr && is_reg(paddr, tcp_pkg::A_PERIOD)) begin
         s_next.period = pwdata[15:0];
      end

      // Paired mode and which match register is active
      linked = s_reg.cctl[0][tcp_pkg::B_MHI]; // see RL4 // see RL13 // see RL17
      if (wr && is_reg(paddr, tcp_pkg::A_C0VAL)) begin
         s_next.cmatch[0] = pwdata[15:0];
         s_next.last_sel = 1'b0;
      end
      if (wr && is_reg(paddr, tcp_pkg::A_C1VAL)) begin
         s_next.cmatch[1] = pwdata[15:0];
         s_next.last_sel = linked;
      end
      if (!linked) begin
         s_next.act_sel = 1'b0;
         s_next.last_sel = 1'b0;
      end else if (cnt_wrap) begin
         s_next.act_sel = s_next.last_sel; // see RL5
      end

      ch_match = linked & s_reg.act_sel ? s_reg.cmatch[1] : s_reg.cmatch[0];
      for (int i = 0; i < 2; i++) begin
         ch_act[i] = ~s_reg.cctl[i][tcp_pkg::B_ALO];
         // Channel 1 is idle and released while paired
         ch_en[i] = (s_reg.cctl[i][tcp_pkg::B_MHI] |
                     s_reg.cctl[i][tcp_pkg::B_MLO]) &
                    ~(i == 1 && linked); // see RL6 // see RL7
         ch_hit[i] = ch_en[i] & cnt_adv &
                     (cnt_val == (i == 0 ? ch_match : s_reg.cmatch[1])); // see RL12
         s_next.oe[i] = ch_en[i]; // see RL27
         if (ch_en[i]) begin
            if (s_reg.cctl[i][tcp_pkg::B_FULL] & ~s_reg.cctl[i][tcp_pkg::B_TOG]) begin
               s_next.pin[i] = ch_act[i]; // see RL19
            end else begin
               // Wrap toggle first so a compare at zero still gives 0% duty
               if (cnt_wrap & s_reg.cctl[i][tcp_pkg::B_TOG]) begin
                  s_next.pin[i] = ~s_reg.pin[i]; // see RL9 // see RL18
               end
               if (ch_hit[i]) begin
                  unique case (s_reg.cctl[i][tcp_pkg::B_ALO +: 2]) // see RL14
                     tcp_pkg::ACT_TOG: s_next.pin[i] = ~s_next.pin[i];
                     tcp_pkg::ACT_CLR: s_next.pin[i] = 1'b0; // see RL10
                     tcp_pkg::ACT_SET: s_next.pin[i] = 1'b1;
                     default: s_next.pin[i] = s_next.pin[i];
                  endcase
               end
            end
         end
         if (rd && is_reg(paddr, i == 0 ? tcp_pkg::A_C0CTL : tcp_pkg::A_C1CTL) &&
             s_reg.cctl[i][tcp_pkg::B_FLAG]) begin
            s_next.carmed[i] = 1'b1;
         end
         if (wr && is_reg(paddr, i == 0 ? tcp_pkg::A_C0CTL : tcp_pkg::A_C1CTL)) begin
            s_next.cctl[i][6:0] = pwdata[6:0] & tcp_pkg::CCTL_WMASK;
            if (i == 1) begin
               s_next.cctl[i][tcp_pkg::B_MHI] = 1'b0;
            end
            if (s_reg.carmed[i] && !pwdata[tcp_pkg::B_FLAG]) begin
               s_next.cctl[i][tcp_pkg::B_FLAG] = 1'b0;
               s_next.carmed[i] = 1'b0;
            end
         end
         if (ch_hit[i]) begin
            s_next.cctl[i][tcp_pkg::B_FLAG] = 1'b1; // see RL1 // see RL21
            s_next.carmed[i] = 1'b0;
         end
      end

      // Request also serves as the wake source in wait mode
      s_next.irq = (s_next.wflag & s_next.wie) |
                   (s_next.cctl[0][tcp_pkg::B_FLAG] & s_next.cctl[0][tcp_pkg::B_IEN]) |
                   (s_next.cctl[1][tcp_pkg::B_FLAG] & s_next.cctl[1][tcp_pkg::B_IEN]);
                   // see RL20 // see RL21 // see RL22
   end

   ////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.halt <= tcp_pkg::HALT_RST; // see RL24
         s_reg.period <= tcp_pkg::PERIOD_RST;
         s_reg.cmatch <= {tcp_pkg::MATCH_RST, tcp_pkg::MATCH_RST};
         s_reg.cctl <= {tcp_pkg::CCTL_RST, tcp_pkg::CCTL_RST};
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign chan0_pin_out = s_reg.pin[0];
   assign chan0_pin_oe = s_reg.oe[0];
   assign chan1_pin_out = s_reg.pin[1];
   assign chan1_pin_oe = s_reg.oe[1];
   assign irq = s_reg.irq;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   logic clr_wr;
   assign clr_wr = wr & is_reg(paddr, tcp_pkg::A_CTRL) & pwdata[tcp_pkg::B_CLR];

   property p_halt;
      @(posedge mclk) disable iff (reset)
      s_reg.halt & ~s_reg.clr |=> $stable(cnt_val);
   endproperty
   a_halt: assert property (p_halt) else $error("Counter moved while halted"); // see RL24

   property p_clear;
      @(posedge mclk) disable iff (reset)
      clr_wr |=> s_reg.clr ##1 (cnt_val == 16'h0000);
   endproperty
   a_clear: assert property (p_clear) else $error("Clear did not zero counter"); // see RL25

   property p_wrap_flag;
      @(posedge mclk) disable iff (reset)
      cnt_wrap |=> s_reg.wflag;
   endproperty
   a_wrap_flag: assert property (p_wrap_flag) else $error("Wrap flag not set"); // see RL20

   property p_flag_one;
      @(posedge mclk) disable iff (reset)
      s_reg.wflag & wr & is_reg(paddr, tcp_pkg::A_CTRL) & pwdata[tcp_pkg::B_WFLAG]
      |=> s_reg.wflag;
   endproperty
   a_flag_one: assert property (p_flag_one) else $error("Writing one cleared flag"); // see RL26

   property p_flag_unarmed;
      @(posedge mclk) disable iff (reset)
      s_reg.wflag & ~s_reg.armed & ~rd |=> s_reg.wflag;
   endproperty
   a_flag_unarmed: assert property (p_flag_unarmed) else $error("Flag cleared unarmed"); // see RL26

   property p_irq;
      @(posedge mclk) disable iff (reset)
      s_reg.wflag & s_reg.wie |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("Wrap request missing"); // see RL20

   property p_chan_flag;
      @(posedge mclk) disable iff (reset)
      ch_hit[0] |=> s_reg.cctl[0][tcp_pkg::B_FLAG];
   endproperty
   a_chan_flag: assert property (p_chan_flag) else $error("Channel flag not set"); // see RL21

   property p_link_oe;
      @(posedge mclk) disable iff (reset)
      linked |=> ~chan1_pin_oe;
   endproperty
   a_link_oe: assert property (p_link_oe) else $error("Channel 1 driven while paired"); // see RL27

   property p_full;
      @(posedge mclk) disable iff (reset)
      ch_en[0] & s_reg.cctl[0][tcp_pkg::B_FULL] & ~s_reg.cctl[0][tcp_pkg::B_TOG]
      |=> chan0_pin_out == $past(ch_act[0]);
   endproperty
   a_full: assert property (p_full) else $error("Full duty level wrong"); // see RL19

   property p_toggle;
      @(posedge mclk) disable iff (reset)
      ch_en[0] & cnt_wrap & ~ch_hit[0] & s_reg.cctl[0][tcp_pkg::B_TOG]
      |=> chan0_pin_out != $past(chan0_pin_out);
   endproperty
   a_toggle: assert property (p_toggle) else $error("No toggle at wrap"); // see RL9

   property p_sel;
      @(posedge mclk) disable iff (reset)
      linked & cnt_wrap & ~wr |=> s_reg.act_sel == $past(s_reg.last_sel);
   endproperty
   a_sel: assert property (p_sel) else $error("Pair not swapped at wrap"); // see RL5

   property p_stop;
      @(posedge mclk) disable iff (reset)
      stop_mode ##1 stop_mode & ~s_reg.clr |-> $stable(cnt_val);
   endproperty
   a_stop: assert property (p_stop) else $error("Counter moved in stop"); // see RL23

   c_wrap: cover property (@(posedge mclk) disable iff (reset) cnt_wrap & s_reg.wie);
   c_swap: cover property (@(posedge mclk) disable iff (reset) $rose(s_reg.act_sel));
   c_pulse: cover property (@(posedge mclk) disable iff (reset) ch_hit[0] ##[1:300] cnt_wrap);
   c_irq: cover property (@(posedge mclk) disable iff (reset) $rose(irq));
endmodule

// [sim/tcp_load.sv]
/*
 * External load on the two timer channel pins.
 * Assumes the port logic drives a released pin with the inverse of its last level.
 */
`timescale 1ns/1ps
module tcp_load (
   input wire logic mclk, // System clock
   input wire logic clr, // Restart the high-time count
   input wire logic out0, // chan0_pin drive level
   input wire logic oe0, // chan0_pin output enable
   input wire logic out1, // chan1_pin drive level
   input wire logic oe1, // chan1_pin output enable
   output logic w0, // chan0_pin wire level
   output logic w1, // chan1_pin wire level
   output logic [15:0] hi0, // Cycles chan0_pin was high
   output logic [15:0] hi1 // Cycles chan1_pin was high
);
   logic l0 = 1'b0;
   logic l1 = 1'b0;
   // A released pin never holds its last value
   assign w0 = oe0 ? out0 : ~l0;
   assign w1 = oe1 ? out1 : ~l1;
   initial hi0 = 16'h0000;
   initial hi1 = 16'h0000;
   always @(posedge mclk) begin
      l0 <= w0;
      l1 <= w1;
      hi0 <= clr ? {15'h0000, w0} : hi0 + {15'h0000, w0};
      hi1 <= clr ? {15'h0000, w1} : hi1 + {15'h0000, w1};
   end
endmodule

// [sim/testbench.sv]
/*
 * Self-checking bench for the compare/PWM timer over APB.
 * Assumes prescale 0, so the counter steps on every mclk.
 */
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [15:0] p;
      logic [15:0] m;
      logic [7:0] c;
      logic [15:0] h;
   } tcp_row_t;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic stop_mode = 1'b0;
   logic lclr = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, o0, e0, o1, e1, irq, w0, w1;
   logic [15:0] hi0, hi1;
   logic [31:0] r, a;
   logic err;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   tcp_row_t rows [7];
   always #50 mclk = ~mclk;
   tcp_top uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_mode(stop_mode), .chan0_pin_out(o0), .chan0_pin_oe(e0),
      .chan1_pin_out(o1), .chan1_pin_oe(e1), .irq(irq));
   tcp_load load (.mclk(mclk), .clr(lclr), .out0(o0), .oe0(e0), .out1(o1), .oe1(e1),
      .w0(w0), .w1(w1), .hi0(hi0), .hi1(hi1));
   ////////////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         test_done;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         $display("MISMATCH %0t no ready", $time);
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0000_0000);
      chk(r, e);
   endtask
   task meas(input logic [15:0] p, input logic [15:0] h);
      repeat (2 * (p + 1)) @(posedge mclk);
      lclr <= 1'b1;
      @(posedge mclk);
      lclr <= 1'b0;
      repeat (4 * (p + 1) - 1) @(posedge mclk);
      #1;
      chk({16'h0000, hi0}, {16'h0000, h * 16'h0004});
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = '{16'h0003, 16'h0001, 8'h1a, 16'h0001};
      rows[1] = '{16'h0003, 16'h0001, 8'h1e, 16'h0003};
      rows[2] = '{16'h0003, 16'h0001, 8'h18, 16'h0000};
      rows[3] = '{16'h0003, 16'h0001, 8'h19, 16'h0004};
      rows[4] = '{16'h00ff, 16'h0080, 8'h1a, 16'h0080};
      rows[5] = '{16'h0003, 16'h0001, 8'h14, 16'h0002};
      rows[6] = '{16'h0003, 16'h0002, 8'h3a, 16'h0002};
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      rd(tcp_pkg::A_CTRL, 32'h0000_0020);
      rd(tcp_pkg::A_PERIOD, 32'h0000_ffff);
      rd(tcp_pkg::A_COUNT, 32'h0000_0000);
      apb(1'b0, 8'h1c, 32'h0000_0000);
      chk({31'h0000_0000, err}, 32'h0000_0001);
      chk(r, 32'h0000_0000);
      $display("test reset and unmapped done");
      foreach (rows[i]) begin
         wr(tcp_pkg::A_CTRL, 32'h0000_0030);
         wr(tcp_pkg::A_PERIOD, 32'(rows[i].p));
         wr(tcp_pkg::A_C0VAL, 32'(rows[i].m));
         wr(tcp_pkg::A_C0CTL, 32'(rows[i].c));
         wr(tcp_pkg::A_CTRL, 32'h0000_0000);
         meas(rows[i].p, rows[i].h);
      end
      $display("test pwm table done");
      chk(e0, 1'b1);
      chk(e1, 1'b0);
      wr(tcp_pkg::A_C1VAL, 32'h0000_0003);
      meas(16'h0003, 16'h0003);
      wr(tcp_pkg::A_C1CTL, 32'h0000_001e);
      meas(16'h0003, 16'h0003);
      chk(e1, 1'b0);
      wr(tcp_pkg::A_C0VAL, 32'h0000_0001);
      meas(16'h0003, 16'h0001);
      $display("test paired done");
      wr(tcp_pkg::A_CTRL, 32'h0000_0020);
      rd(tcp_pkg::A_CTRL, 32'h0000_00a0);
      #1 chk(irq, 1'b0);
      wr(tcp_pkg::A_CTRL, 32'h0000_00e0);
      #1 chk(irq, 1'b1);
      rd(tcp_pkg::A_CTRL, 32'h0000_00e0);
      wr(tcp_pkg::A_CTRL, 32'h0000_0060);
      rd(tcp_pkg::A_CTRL, 32'h0000_0060);
      #1 chk(irq, 1'b0);
      rd(tcp_pkg::A_C0CTL, 32'h0000_00ba);
      wr(tcp_pkg::A_C0CTL, 32'h0000_00fa);
      #1 chk(irq, 1'b1);
      rd(tcp_pkg::A_C0CTL, 32'h0000_00fa);
      wr(tcp_pkg::A_C0CTL, 32'h0000_007a);
      #1 chk(irq, 1'b0);
      $display("test flags done");
      wr(tcp_pkg::A_PERIOD, 32'h0000_ffff);
      apb(1'b0, tcp_pkg::A_COUNT, 32'h0000_0000);
      a = r;
      repeat (5) @(posedge mclk);
      rd(tcp_pkg::A_COUNT, a);
      wr(tcp_pkg::A_CTRL, 32'h0000_0030);
      rd(tcp_pkg::A_COUNT, 32'h0000_0000);
      rd(tcp_pkg::A_CTRL, 32'h0000_0020);
      wr(tcp_pkg::A_CTRL, 32'h0000_0000);
      repeat (20) @(posedge mclk);
      stop_mode <= 1'b1;
      apb(1'b0, tcp_pkg::A_COUNT, 32'h0000_0000);
      a = r;
      repeat (10) @(posedge mclk);
      rd(tcp_pkg::A_COUNT, a);
      stop_mode <= 1'b0;
      repeat (5) @(posedge mclk);
      apb(1'b0, tcp_pkg::A_COUNT, 32'h0000_0000);
      chk(32'(r > a), 32'h0000_0001);
      $display("test halt clear stop done");
      wr(tcp_pkg::A_CTRL, 32'h0000_0007);
      rd(tcp_pkg::A_CTRL, 32'h0000_0007);
      apb(1'b0, tcp_pkg::A_COUNT, 32'h0000_0000);
      a = r;
      repeat (5) @(posedge mclk);
      rd(tcp_pkg::A_COUNT, a);
      $display("test external clock select done");
      wr(tcp_pkg::A_CTRL, 32'h0000_0030);
      rd(tcp_pkg::A_C0CTL, 32'h0000_00fa);
      wr(tcp_pkg::A_PERIOD, 32'h0000_0003);
      wr(tcp_pkg::A_C0VAL, 32'h0000_0002);
      wr(tcp_pkg::A_C0CTL, 32'h0000_005a);
      wr(tcp_pkg::A_CTRL, 32'h0000_0000);
      while (irq !== 1'b1) @(posedge mclk);
      chk(w0, 1'b0);
      wr(tcp_pkg::A_C0VAL, 32'h0000_0001);
      meas(16'h0003, 16'h0001);
      chk({16'h0000, hi1}, 32'h0000_0004);
      chk(e1, 1'b1);
      $display("test unbuffered update done");
      test_done;
   end
endmodule
